/* File: hdl/ssd_seq_decode.sv */
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ssd_seq_decode
  import ssd_pkg::*;
(
  // clock, reset, enable
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [DATA_W-1:0] S_AXI_WDATA_I,
  input wire logic [DATA_W/8-1:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [DATA_W-1:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // sequence inputs and drive protection
  input wire logic [N_IN-1:0] SEQ_IN_I,
  input wire logic ALARM_EVENT_I,
  input wire logic ALARM_KEEP_I,
  // decoded actions
  output ssd_ctrl_s CTRL_O,
  output logic [SPEED_W-1:0] SPEED_CMD_O,
  output logic IRQ_O
);

  // merge write data into a register under byte strobes
  function automatic logic [DATA_W-1:0] apply_strb(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [DATA_W/8-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < DATA_W/8; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  // word index of an address within a register array, or n when outside
  function automatic logic [4:0] arr_idx(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] base,
    input int unsigned n
  );
    logic [ADDR_W-1:0] ofs;
    ofs = addr - base;
    if (addr >= base && ofs[1:0] == 2'h0 && ofs[ADDR_W-1:2] < n[ADDR_W-3:0])
      return ofs[6:2];
    else
      return n[4:0];
  endfunction

  // register state
  logic [DATA_W-1:0] config_q;
  logic [DATA_W-1:0] func_q [N_IN];
  logic [SPEED_W-1:0] speed_q [N_SPEED];
  logic [IRQ_W-1:0] int_status_q;
  logic [IRQ_W-1:0] int_mask_q;

  // bus state
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W/8-1:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic wr_do;
  logic wr_ok;
  logic [4:0] wr_func;
  logic [4:0] wr_speed;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  logic [4:0] rd_func;
  logic [4:0] rd_speed;
  logic [DATA_W-1:0] mask_wr;
  logic [DATA_W-1:0] speed_wr;

  // decode state
  logic [N_IN-1:0] sync1_q;
  logic [N_IN-1:0] sync2_q;
  logic [N_IN-1:0] lvl;
  logic [N_FN-1:0] fn_act;
  logic speed_mode_q;
  logic speed_mode_d;
  logic eclr_prev_q;
  logic arst_prev_q;
  logic alarm_q;
  logic keep_q;
  logic estop_q;
  logic eclr_lvl;
  logic eclr_evt;
  logic arst_rise;
  logic stop_in;
  ssd_ctrl_s ctrl_q;
  ssd_ctrl_s ctrl_d;
  logic [SPEED_W-1:0] speed_cmd_q;
  logic [SPEED_W-1:0] speed_cmd_d;
  logic [IRQ_W-1:0] irq_evt;

  // config fields
  logic [2:0] mode_par;
  logic [2:0] tl_par;
  logic [1:0] df_par;
  logic [1:0] zs_par;
  logic [1:0] gain_par;
  assign mode_par = config_q[CFG_MODE_LSB +: 3];
  assign tl_par = config_q[CFG_TL_LSB +: 3];
  assign df_par = config_q[CFG_DF_LSB +: 2];
  assign zs_par = config_q[CFG_ZS_LSB +: 2];
  assign gain_par = config_q[CFG_GAIN_LSB +: 2];

  // write address and data are taken separately, in either order
  // a frozen block must not signal a take that it will not record
  assign S_AXI_AWREADY_O = !aw_hold_q && !bvalid_q && CE_I;
  assign S_AXI_WREADY_O = !w_hold_q && !bvalid_q && CE_I;
  assign wr_do = aw_hold_q && w_hold_q && !bvalid_q && CE_I;
  assign wr_func = arr_idx(awaddr_q, FUNC_BASE, N_IN);
  assign wr_speed = arr_idx(awaddr_q, SPEED_BASE, N_SPEED);
  assign wr_ok = (awaddr_q == CONFIG_OFS) || (awaddr_q == STATUS_OFS) ||
                 (awaddr_q == INT_STATUS_OFS) || (awaddr_q == INT_MASK_OFS) ||
                 (awaddr_q == SPEED_CMD_OFS) || (wr_func != N_IN[4:0]) ||
                 (wr_speed != N_SPEED[4:0]);

  // strobe-merged words for the narrow registers
  assign mask_wr = apply_strb({{(DATA_W-IRQ_W){1'b0}}, int_mask_q},
                              wdata_q, wstrb_q);
  assign speed_wr = apply_strb({{(DATA_W-SPEED_W){1'b0}},
                               speed_q[wr_speed[2:0]]}, wdata_q, wstrb_q);

  // write channel capture and response
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (wr_do)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY_I)
        bvalid_q <= 1'b0;
    end
  end
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;

  // read mux; unmapped words read zero with an error response
  always_comb
  begin
    rd_func = arr_idx(S_AXI_ARADDR_I, FUNC_BASE, N_IN);
    rd_speed = arr_idx(S_AXI_ARADDR_I, SPEED_BASE, N_SPEED);
    rd_data = '0;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR_I == CONFIG_OFS)
      rd_data = config_q;
    else if (S_AXI_ARADDR_I == STATUS_OFS)
      rd_data = {{(DATA_W-$bits(ssd_ctrl_s)){1'b0}}, ctrl_q};
    else if (S_AXI_ARADDR_I == INT_STATUS_OFS)
      rd_data = {{(DATA_W-IRQ_W){1'b0}}, int_status_q};
    else if (S_AXI_ARADDR_I == INT_MASK_OFS)
      rd_data = {{(DATA_W-IRQ_W){1'b0}}, int_mask_q};
    else if (S_AXI_ARADDR_I == SPEED_CMD_OFS)
      rd_data = {{(DATA_W-SPEED_W){1'b0}}, speed_cmd_q};
    else if (rd_func != N_IN[4:0])
      rd_data = func_q[rd_func[3:0]];
    else if (rd_speed != N_SPEED[4:0])
      rd_data = {{(DATA_W-SPEED_W){1'b0}}, speed_q[rd_speed[2:0]]};
    else
      rd_ok = 1'b0;
  end

  // read channel: one read in flight, data registered
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else if (CE_I)
    begin
      if (S_AXI_ARVALID_I && !rvalid_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && S_AXI_RREADY_I)
        rvalid_q <= 1'b0;
    end
  end
  assign S_AXI_ARREADY_O = !rvalid_q && CE_I;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;

  // configuration and mask registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      config_q <= CONFIG_RST;
      int_mask_q <= '0;
    end
    else if (wr_do)
    begin
      if (awaddr_q == CONFIG_OFS)
        config_q <= apply_strb(config_q, wdata_q, wstrb_q);
      if (awaddr_q == INT_MASK_OFS)
        int_mask_q <= mask_wr[IRQ_W-1:0];
    end
  end

  // per-input function and polarity words, internal speed table
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < N_IN; i++)
        func_q[i] <= FUNC_RST;
      for (int i = 0; i < N_SPEED; i++)
        speed_q[i] <= SPEED_RST;
    end
    else if (wr_do)
    begin
      if (wr_func != N_IN[4:0])
        func_q[wr_func[3:0]] <= apply_strb(func_q[wr_func[3:0]], wdata_q,
                                           wstrb_q);
      if (wr_speed != N_SPEED[4:0])
        speed_q[wr_speed[2:0]] <= speed_wr[SPEED_W-1:0];
    end
  end

  // two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (CE_I)
    begin
      sync1_q <= SEQ_IN_I;
      sync2_q <= sync1_q;
    end
  end

  // function map: polarity, default table per mode, fixed positions
  always_comb
  begin
    ssd_fn_t f;
    f = FN_NONE;
    fn_act = '0;
    for (int p = 0; p < N_IN; p++)
    begin
      lvl[p] = sync2_q[p] ^ func_q[p][FN_INV_BIT];
      f = func_q[p][FN_LSB +: FN_W];
      if (f == FN_DEFAULT)
        f = speed_mode_q ? DEF_SPD[p] : DEF_POS[p];
      if (f == FN_ECLR && p[3:0] != ECLR_POS)
        f = FN_NONE;
      if (f == FN_INH && p[3:0] != INH_POS)
        f = FN_NONE;
      if (lvl[p])
        fn_act[f] = 1'b1;
    end
  end

  // mode select uses the registered mode for the map, avoiding a loop
  always_comb
  begin
    if (mode_par == MODE_SWITCH)
      speed_mode_d = fn_act[FN_MODE];
    else
      speed_mode_d = (mode_par == MODE_SPD);
  end

  assign stop_in = fn_act[FN_STOP];
  assign eclr_lvl = fn_act[FN_ECLR] && !speed_mode_q;
  assign arst_rise = fn_act[FN_ARST] && !arst_prev_q;
  // clear on edge or level; an alarm reset also clears the counter
  assign eclr_evt = ((config_q[CFG_ECC_BIT] == ECC_EDGE) ?
                     (eclr_lvl && !eclr_prev_q) : eclr_lvl) ||
                    arst_rise;

  // edge history and active mode
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      speed_mode_q <= 1'b0;
      eclr_prev_q <= 1'b0;
      arst_prev_q <= 1'b0;
    end
    else if (CE_I)
    begin
      speed_mode_q <= speed_mode_d;
      eclr_prev_q <= eclr_lvl;
      arst_prev_q <= fn_act[FN_ARST];
    end
  end

  // alarm latch: a new alarm beats a reset in the same cycle;
  // non-resettable alarms leave only by system reset
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      alarm_q <= 1'b0;
      keep_q <= 1'b0;
      estop_q <= 1'b0;
    end
    else if (CE_I)
    begin
      if (ALARM_EVENT_I)
        alarm_q <= 1'b1;
      else if (arst_rise && !keep_q)
        alarm_q <= 1'b0;
      if (ALARM_EVENT_I && ALARM_KEEP_I)
        keep_q <= 1'b1;
      if (stop_in)
        estop_q <= 1'b1;
      else if (arst_rise)
        estop_q <= 1'b0;
    end
  end

  // decoded actions, registered before leaving the block
  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.servo_on = fn_act[FN_RUN] && !alarm_q && !estop_q;
    ctrl_d.alarm = alarm_q;
    ctrl_d.estop_error = estop_q;
    ctrl_d.error_clear = eclr_evt;
    ctrl_d.alarm_clear = arst_rise && !keep_q;
    ctrl_d.speed_mode = speed_mode_q;
    ctrl_d.pulse_inhibit = (config_q[CFG_INH_BIT] == INH_ON) &&
                           fn_act[FN_INH] && !speed_mode_q;
    ctrl_d.torque_limit_alt = (tl_par == TL_SW_A || tl_par == TL_SW_B) &&
                              fn_act[FN_TLSW];
    ctrl_d.gain_set2 = (gain_par == GAIN_INPUT) && fn_act[FN_GAIN_SET_SELECT_IN];
    ctrl_d.inertia_ratio2 = fn_act[FN_INERTIA_RATIO_SELECT_IN];
    ctrl_d.zero_speed = (zs_par != ZS_OFF) && fn_act[FN_ZERO];
    ctrl_d.speed_reverse = (config_q[CFG_DIR_BIT] == DIR_INPUT) &&
                           fn_act[FN_SIGN];
    if (!speed_mode_q)
      ctrl_d.gear_sel = {fn_act[FN_GEARB], fn_act[FN_GEARA]};
    if (df_par == DF_TWO)
      ctrl_d.damping_sel = {fn_act[FN_DFB], fn_act[FN_DFA]};
    else if (df_par == DF_ONE)
      ctrl_d.damping_sel = {1'b0, fn_act[FN_DFA]};
    ctrl_d.speed_sel = {fn_act[FN_INTERNAL_SPEED_SEL1], fn_act[FN_INTERNAL_SPEED_SEL0],
                        fn_act[FN_VSEL0]};
  end

  // speed command: table entry, direction from sign input, forced zero
  always_comb
  begin
    logic [SPEED_W-1:0] raw;
    logic [SPEED_W-1:0] mag;
    raw = speed_q[ctrl_d.speed_sel];
    mag = raw[SPEED_W-1] ? (~raw + 1'b1) : raw;
    speed_cmd_d = raw;
    if (config_q[CFG_DIR_BIT] == DIR_INPUT)
      speed_cmd_d = ctrl_d.speed_reverse ? (~mag + 1'b1) : mag;
    // the motor must stop on estop even before servo-off lands
    if (!speed_mode_q || ctrl_d.zero_speed || estop_q)
      speed_cmd_d = '0;
  end

  // output registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_q <= '0;
      speed_cmd_q <= '0;
    end
    else if (CE_I)
    begin
      ctrl_q <= ctrl_d;
      speed_cmd_q <= speed_cmd_d;
    end
  end
  assign CTRL_O = ctrl_q;
  assign SPEED_CMD_O = speed_cmd_q;

  // interrupt events
  assign irq_evt[IRQ_ALARM] = ALARM_EVENT_I && !alarm_q;
  assign irq_evt[IRQ_ESTOP] = stop_in && !estop_q;
  assign irq_evt[IRQ_ECLR] = eclr_evt;
  assign irq_evt[IRQ_MODE] = speed_mode_d != speed_mode_q;

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
      int_status_q <= '0;
    else if (CE_I)
    begin
      if (wr_do && awaddr_q == INT_STATUS_OFS && wstrb_q[0])
        int_status_q <= (int_status_q & ~wdata_q[IRQ_W-1:0]) | irq_evt;
      else
        int_status_q <= int_status_q | irq_evt;
    end
  end
  assign IRQ_O = |(int_status_q & int_mask_q);

endmodule
`default_nettype wire

/* File: hdl/ssd_pkg.sv */
`default_nettype none
package ssd_pkg;
  // sizes
  localparam int unsigned N_IN = 10;
  localparam int unsigned N_SPEED = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned FN_W = 5;
  localparam int unsigned N_FN = 32;
  localparam int unsigned IRQ_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] FUNC_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] SPEED_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] SPEED_CMD_OFS = 8'h60;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // config register fields
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_ECC_BIT = 4;
  localparam int unsigned CFG_INH_BIT = 8;
  localparam int unsigned CFG_TL_LSB = 12;
  localparam int unsigned CFG_DF_LSB = 16;
  localparam int unsigned CFG_ZS_LSB = 20;
  localparam int unsigned CFG_DIR_BIT = 24;
  localparam int unsigned CFG_GAIN_LSB = 28;
  localparam logic [DATA_W-1:0] CONFIG_RST = 32'h0000_0100;

  // parameter values that enable or disable a function
  localparam logic [2:0] MODE_SPD = 3'h1;
  localparam logic [2:0] MODE_SWITCH = 3'h3;
  localparam logic ECC_EDGE = 1'b0;
  localparam logic INH_ON = 1'b0;
  localparam logic [2:0] TL_SW_A = 3'h3;
  localparam logic [2:0] TL_SW_B = 3'h6;
  localparam logic [1:0] DF_ONE = 2'h1;
  localparam logic [1:0] DF_TWO = 2'h2;
  localparam logic [1:0] ZS_OFF = 2'h0;
  localparam logic DIR_INPUT = 1'b1;
  localparam logic [1:0] GAIN_INPUT = 2'h2;

  // input function register fields
  localparam int unsigned FN_LSB = 0;
  localparam int unsigned FN_INV_BIT = 8;
  localparam logic [DATA_W-1:0] FUNC_RST = 32'h0000_0000;
  localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;

  // input function codes
  typedef logic [FN_W-1:0] ssd_fn_t;
  localparam ssd_fn_t FN_DEFAULT = 5'h00;
  localparam ssd_fn_t FN_NONE = 5'h01;
  localparam ssd_fn_t FN_RUN = 5'h02;
  localparam ssd_fn_t FN_ECLR = 5'h03;
  localparam ssd_fn_t FN_ARST = 5'h04;
  localparam ssd_fn_t FN_MODE = 5'h05;
  localparam ssd_fn_t FN_INH = 5'h06;
  localparam ssd_fn_t FN_VSEL0 = 5'h07;
  localparam ssd_fn_t FN_INTERNAL_SPEED_SEL0 = 5'h08;
  localparam ssd_fn_t FN_INTERNAL_SPEED_SEL1 = 5'h09;
  localparam ssd_fn_t FN_TLSW = 5'h0a;
  localparam ssd_fn_t FN_DFA = 5'h0b;
  localparam ssd_fn_t FN_DFB = 5'h0c;
  localparam ssd_fn_t FN_GEARA = 5'h0d;
  localparam ssd_fn_t FN_GEARB = 5'h0e;
  localparam ssd_fn_t FN_ZERO = 5'h0f;
  localparam ssd_fn_t FN_SIGN = 5'h10;
  localparam ssd_fn_t FN_STOP = 5'h11;
  localparam ssd_fn_t FN_INERTIA_RATIO_SELECT_IN = 5'h12;
  localparam ssd_fn_t FN_GAIN_SET_SELECT_IN = 5'h13;

  // fixed positions and default maps, index 0..9 = input 1..10
  localparam logic [3:0] ECLR_POS = 4'h6;
  localparam logic [3:0] INH_POS = 4'h9;
  localparam ssd_fn_t DEF_POS [N_IN] = '{FN_NONE, FN_NONE, FN_DFA, FN_GAIN_SET_SELECT_IN,
    FN_GEARA, FN_RUN, FN_ECLR, FN_ARST, FN_MODE, FN_INH};
  localparam ssd_fn_t DEF_SPD [N_IN] = '{FN_NONE, FN_NONE, FN_NONE, FN_GAIN_SET_SELECT_IN,
    FN_INTERNAL_SPEED_SEL1, FN_RUN, FN_INTERNAL_SPEED_SEL0, FN_ARST, FN_MODE, FN_VSEL0};

  // interrupt bits
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_ESTOP = 1;
  localparam int unsigned IRQ_ECLR = 2;
  localparam int unsigned IRQ_MODE = 3;

  // decoded control actions, also the status register layout
  typedef struct packed {
    logic [2:0] speed_sel;
    logic [1:0] damping_sel;
    logic [1:0] gear_sel;
    logic speed_reverse;
    logic zero_speed;
    logic inertia_ratio2;
    logic gain_set2;
    logic torque_limit_alt;
    logic pulse_inhibit;
    logic speed_mode;
    logic alarm_clear;
    logic error_clear;
    logic estop_error;
    logic alarm;
    logic servo_on;
  } ssd_ctrl_s;
endpackage
`default_nettype wire

/* File: verification/ssd_seq_decode_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module ssd_seq_decode_checker
  import ssd_pkg::*;
(
  // clock, reset, enable
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // bus answers
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [DATA_W-1:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // events and decoded actions
  input wire logic ALARM_EVENT_I,
  input wire ssd_ctrl_s CTRL_O,
  input wire logic [SPEED_W-1:0] SPEED_CMD_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // reset is sampled regardless of the enable
  a_reset_clear: assert property (disable iff (1'b0)
    !RST_N_I |=> CTRL_O == '0 && !IRQ_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O)
    else $error("outputs not cleared by reset");
  a_servo_gate: assert property (
    CTRL_O.servo_on |-> !CTRL_O.alarm && !CTRL_O.estop_error)
    else $error("servo on while faulted");
  a_alarm_latch: assert property (
    ALARM_EVENT_I && CE_I ##1 CE_I |=> CTRL_O.alarm)
    else $error("alarm not latched");
  a_aclr_pulse: assert property (
    CTRL_O.alarm_clear && CE_I |=> !CTRL_O.alarm_clear)
    else $error("alarm clear longer than one cycle");
  a_aclr_eclr: assert property (
    CTRL_O.alarm_clear |-> CTRL_O.error_clear)
    else $error("alarm clear without error clear");
  // one cycle of slack so a mode or flag edge may settle
  a_estop_speed: assert property (
    CTRL_O.estop_error && $past(CTRL_O.estop_error) |-> SPEED_CMD_O == 16'h0)
    else $error("speed command during stop");
  a_zero_speed: assert property (
    CTRL_O.zero_speed && $past(CTRL_O.zero_speed) |-> SPEED_CMD_O == 16'h0)
    else $error("speed command while forced zero");
  a_pos_speed: assert property (
    !CTRL_O.speed_mode && !$past(CTRL_O.speed_mode) |-> SPEED_CMD_O == 16'h0)
    else $error("speed command in position mode");
  a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped early");
  a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped early");

  // main scenarios reached
  c_servo: cover property ($rose(CTRL_O.servo_on));
  c_estop: cover property (CTRL_O.estop_error);
  c_aclr: cover property (CTRL_O.alarm_clear);
  c_irq: cover property (IRQ_O);
endmodule

bind ssd_seq_decode ssd_seq_decode_checker u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .ALARM_EVENT_I(ALARM_EVENT_I), .CTRL_O(CTRL_O),
  .SPEED_CMD_O(SPEED_CMD_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* File: verification/ssd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ssd_host_model
  import ssd_pkg::*;
(
  // clock and wanted levels
  input wire logic clk_i,
  input wire logic [N_IN-1:0] lvl_i,
  // sequence input pins
  output logic [N_IN-1:0] seq_o = '0
);
  // output card switches just after the edge, unrelated to decode timing
  always @(posedge clk_i)
  begin
    seq_o <= lvl_i;
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ssd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic alm = 1'b0;
  logic keep = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] awa = '0;
  logic [ADDR_W-1:0] ara = '0;
  logic [DATA_W-1:0] wd = '0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic [N_IN-1:0] lvl = '0;
  logic [N_IN-1:0] seq;
  logic awr, wr, bv, arr, rv, irq;
  logic [1:0] br, rr, resp;
  logic [DATA_W-1:0] rd, rdv;
  logic [SPEED_W-1:0] spd;
  ssd_ctrl_s ctrl;
  int errors = 0;
  int total_checks = 0;
  int pb = 3;
  int hits;
  // single-pin functions: code, enabling config, bit in the action word
  ssd_fn_t tc [6] = '{FN_RUN, FN_TLSW, FN_TLSW, FN_INERTIA_RATIO_SELECT_IN, FN_GAIN_SET_SELECT_IN, FN_MODE};
  logic [31:0] ton [6] = '{32'h100, 32'h3100, 32'h6100, 32'h100,
    32'h2000_0100, 32'h103};
  int tbit [6] = '{0, 7, 7, 9, 8, 5};

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  ssd_host_model u_host (.clk_i(clk), .lvl_i(lvl), .seq_o(seq));

  ssd_seq_decode DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .SEQ_IN_I(seq),
    .ALARM_EVENT_I(alm), .ALARM_KEEP_I(keep), .CTRL_O(ctrl),
    .SPEED_CMD_O(spd), .IRQ_O(irq));

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang();
    errors++;
    $display("ERROR bus wait expected answer seen none");
    test_done();
  endtask

  // ready is raised only after valid is seen, so the hold path runs
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv && bry) break;
      if (bv) bry <= 1'b1;
    end
    bry <= 1'b0;
    resp = br;
    if (n == 50) hang();
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv && rry) break;
      if (rv) rry <= 1'b1;
    end
    rry <= 1'b0;
    rdv = rd;
    resp = rr;
    if (n == 50) hang();
  endtask

  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a,
    input logic [31:0] exp, input logic [1:0] er);
    axi_rd(a);
    chk(nm, rdv, exp);
    chk("resp", 32'(resp), 32'(er));
  endtask

  // set pin levels, then count cycles with action bit pb high
  task automatic put(input logic [N_IN-1:0] v);
    lvl <= v;
    hits = 0;
    repeat (8)
    begin
      @(posedge clk);
      hits += int'(ctrl[pb]);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  initial
  begin
    do_reset();
    // reset values, an unmapped word, mask read back
    rchk("config", CONFIG_OFS, CONFIG_RST, RESP_OKAY);
    rchk("func9", FUNC_BASE + 8'h24, FUNC_RST, RESP_OKAY);
    rchk("hole", 8'hfc, 32'h0, RESP_SLVERR);
    axi_wr(8'hfc, 32'h1);
    chk("hole wr", 32'(resp), 32'(RESP_SLVERR));
    axi_wr(INT_MASK_OFS, 32'h6);
    rchk("mask", INT_MASK_OFS, 32'h6, RESP_OKAY);
    // error clear works only on its fixed pin, edge then level
    axi_wr(CONFIG_OFS, 32'h0);
    axi_wr(FUNC_BASE, 32'(FN_ECLR));
    put(10'h001);
    chk("eclr pin", hits, 0);
    put(10'h041);
    chk("eclr edge", hits, 1);
    rchk("int", INT_STATUS_OFS, 32'h4, RESP_OKAY);
    chk("irq", irq, 1);
    axi_wr(INT_STATUS_OFS, 32'h4);
    chk("irq clr", irq, 0);
    axi_wr(CONFIG_OFS, 32'h10);
    put(10'h041);
    chk("eclr level", hits, 8);
    put(10'h000);
    // pulse inhibit: fixed pin and parameter gate
    axi_wr(FUNC_BASE, 32'(FN_INH));
    put(10'h001);
    chk("inh pin", ctrl.pulse_inhibit, 0);
    put(10'h200);
    chk("inh on", ctrl.pulse_inhibit, 1);
    axi_wr(CONFIG_OFS, 32'h100);
    put(10'h200);
    chk("inh off", ctrl.pulse_inhibit, 0);
    // each single-pin function: enabled, inverted, parameter off
    for (int i = 0; i < 6; i++)
    begin
      axi_wr(FUNC_BASE, 32'(tc[i]));
      axi_wr(CONFIG_OFS, ton[i]);
      put(10'h001);
      chk("fn on", ctrl[tbit[i]], 1);
      axi_wr(FUNC_BASE, 32'(tc[i]) | 32'h100);
      put(10'h001);
      chk("fn inv", ctrl[tbit[i]], 0);
      axi_wr(FUNC_BASE, 32'(tc[i]));
      axi_wr(CONFIG_OFS, 32'h100);
      put(10'h001);
      chk("fn off", ctrl[tbit[i]], ton[i] == 32'h100);
    end
    // gear and damping pairs, all four codes
    axi_wr(FUNC_BASE, 32'(FN_GEARA));
    axi_wr(FUNC_BASE + 8'h4, 32'(FN_GEARB));
    axi_wr(FUNC_BASE + 8'h8, 32'(FN_DFA));
    axi_wr(FUNC_BASE + 8'hc, 32'(FN_DFB));
    axi_wr(CONFIG_OFS, 32'h0002_0100);
    for (int k = 0; k < 4; k++)
    begin
      put({6'h0, k[1:0], k[1:0]});
      chk("gear", ctrl.gear_sel, k);
      chk("damp", ctrl.damping_sel, k);
    end
    for (int k = 0; k < 4; k++)
      axi_wr(FUNC_BASE + 8'(4 * k), 32'h0);
    // internal speeds on the speed-mode default pins
    axi_wr(CONFIG_OFS, 32'h101);
    for (int k = 0; k < 8; k++)
      axi_wr(SPEED_BASE + 8'(4 * k), 32'(16'h0110 + 16'(k)));
    for (int k = 0; k < 8; k++)
    begin
      put({k[0], 2'h0, k[1], 1'b0, k[2], 4'h0});
      chk("sel", ctrl.speed_sel, k);
      chk("cmd", spd, 16'h0110 + 16'(k));
    end
    // sign and zero speed
    axi_wr(FUNC_BASE, 32'(FN_SIGN));
    axi_wr(FUNC_BASE + 8'h4, 32'(FN_ZERO));
    axi_wr(CONFIG_OFS, 32'h0110_0101);
    put(10'h001);
    chk("rev", spd, 16'hfef0);
    put(10'h000);
    chk("fwd", spd, 16'h0110);
    rchk("cmd reg", SPEED_CMD_OFS, 32'h110, RESP_OKAY);
    put(10'h002);
    chk("zero", spd, 16'h0);
    chk("zflag", ctrl.zero_speed, 1);
    axi_wr(CONFIG_OFS, 32'h0100_0101);
    put(10'h002);
    chk("zero off", spd, 16'h0110);
    // stop, alarm, alarm reset
    axi_wr(FUNC_BASE + 8'h4, 32'h0);
    axi_wr(FUNC_BASE, 32'(FN_STOP));
    axi_wr(CONFIG_OFS, 32'h100);
    axi_wr(INT_STATUS_OFS, 32'hf);
    chk("irq idle", irq, 0);
    put(10'h021);
    chk("estop", ctrl.estop_error, 1);
    chk("servo", ctrl.servo_on, 0);
    chk("irq stop", irq, 1);
    alm <= 1'b1;
    put(10'h020);
    alm <= 1'b0;
    chk("estop held", ctrl.estop_error, 1);
    chk("alarm set", ctrl.alarm, 1);
    pb = 4;
    put(10'h0a0);
    chk("aclr", hits, 1);
    chk("alarm", ctrl.alarm, 0);
    chk("estop gone", ctrl.estop_error, 0);
    chk("servo back", ctrl.servo_on, 1);
    // enable low freezes the input pipeline and the actions
    ce <= 1'b0;
    put(10'h000);
    chk("ce hold", ctrl.servo_on, 1);
    ce <= 1'b1;
    // a lasting alarm survives the alarm reset input
    alm <= 1'b1;
    keep <= 1'b1;
    put(10'h020);
    alm <= 1'b0;
    keep <= 1'b0;
    put(10'h0a0);
    chk("alarm kept", ctrl.alarm, 1);
    axi_wr(INT_MASK_OFS, 32'h0);
    chk("irq masked", irq, 0);
    // reset in mid-run clears the lasting alarm
    do_reset();
    chk("alarm rst", ctrl.alarm, 0);
    rchk("config rst", CONFIG_OFS, CONFIG_RST, RESP_OKAY);
    test_done();
  end
endmodule
`default_nettype wire
